// ==== verilog/eiu_map.vh ====
`ifndef EIU_MAP_VH
`define EIU_MAP_VH

// ****************************************************************
// Register word indices; the byte address is four times the index
// ****************************************************************
`define EIU_OFS_ASYNC_SENSE 4'h0
`define EIU_OFS_SYNC_SENSE 4'h1
`define EIU_OFS_ENABLE_MASK 4'h2
`define EIU_OFS_REQ_FLAGS 4'h3
`define EIU_OFS_PIN_STATUS 4'h4
`define EIU_WORD_LSB 2
`define EIU_WORD_MSB 5

// ****************************************************************
// Reset values
// ****************************************************************
`define EIU_RST_ASYNC_SENSE 8'h00
`define EIU_RST_SYNC_SENSE 8'h00
`define EIU_RST_ENABLE_MASK 8'h00
`define EIU_RST_REQ_FLAGS 8'h00
`define EIU_RST_PIN_SYNC 8'hFF
`define EIU_RST_IRQ_REQ 8'h00
`define EIU_RST_RDATA 32'h0000_0000

// ****************************************************************
// Field layout and sense selection codes
// ****************************************************************
`define EIU_SEL_WIDTH 2
`define EIU_NUM_ASYNC 4
`define EIU_SENSE_LOW 2'h0
`define EIU_SENSE_ANY 2'h1
`define EIU_SENSE_FALL 2'h2
`define EIU_SENSE_RISE 2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define EIU_CLK_PERIOD_NS 8
`define EIU_MIN_PULSE_NS 50
`define EIU_MIN_PULSE_CYC ((`EIU_MIN_PULSE_NS + `EIU_CLK_PERIOD_NS - 1) / `EIU_CLK_PERIOD_NS)

// ****************************************************************
// AHB-Lite codes
// ****************************************************************
`define EIU_HTRANS_NONSEQ_BIT 1
`define EIU_HRESP_OKAY 1'h0

`endif

// ==== verilog/eiu_ext_irq.v ====
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
// ****************************************************************
// External interrupt unit, eight lines, AHB-Lite register slave
// ****************************************************************
// Summary of operation
// - Lines 3..0 request only when global enable and their mask bit are set.
// - Lines 3..0 sense: 00 low, 01 any change, 10 falling, 11 rising edge.
// - Lines 3..0 edges caught; pulses above 50 ns always produce a request.
// - Lines 7..4 are sampled on the clock; pulses over one period are caught.
// - Lines 7..4 sense: 00 low, 01 change, 10 falling, 11 rising between samples.
// - Low-level sensing keeps requesting while the enabled pin stays low.
// - Two sense bits per line, line n at bits 2(n mod 4)+1:2(n mod 4) of its register.
// - Mask bit n enables line n together with the global enable.
// - Pin activity requests even while the pin is driven as an output.
// - A qualifying edge or change sets that line's flag.
// - Flag, mask and global enable all set raise the line's request.
// - Flag clears on handler entry or on writing one; zero writes ignored.
// - A line in low-level sensing always reads its flag as cleared.
// - Sleep with lines 3..0 disabled turns their input buffers off.
// - Edges on lines 7..4 need the I/O clock; low level works without it.
`include "eiu_map.vh"

module eiu_ext_irq (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  input wire [7:0] ext_irq_pin,
  input wire global_irq_en,
  input wire sleep_active,
  input wire io_clk_run,
  input wire [7:0] irq_ack,
  output wire [7:0] irq_req
);

  localparam NUM_LINES = 8;

  // ****************************************************************
  // Sense decode
  // ****************************************************************
  function sense_hit;
    input [1:0] sel;
    input cur;
    input prev;
    begin
      case (sel)
        `EIU_SENSE_ANY: sense_hit = cur ^ prev;
        `EIU_SENSE_FALL: sense_hit = prev & ~cur;
        `EIU_SENSE_RISE: sense_hit = ~prev & cur;
        default: sense_hit = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] async_sense_control_r;
  reg [7:0] sync_sense_control_r;
  reg [7:0] line_enable_mask_r;
  reg [7:0] line_request_flags_r;
  reg [7:0] async_sense_control_nxt;
  reg [7:0] sync_sense_control_nxt;
  reg [7:0] line_enable_mask_nxt;
  wire [7:0] line_request_flags_nxt;
  reg [7:0] pin_meta_r;
  reg [7:0] pin_sync_r;
  reg [7:0] pin_prev_r;
  reg [7:0] irq_req_r;
  reg [31:0] hrdata_r;
  reg [3:0] dp_word_r;
  reg dp_write_r;
  reg dp_valid_r;
  reg [31:0] rd_nxt;
  wire [15:0] sense_all;
  wire [7:0] buf_off;
  wire [7:0] pin_in;
  wire [7:0] flag_clr;
  wire [7:0] level_mode;
  wire [7:0] req_nxt;
  wire ap_take;
  wire wr_go;
  wire [3:0] ap_word;

  assign sense_all = {sync_sense_control_r, async_sense_control_r};

  // ****************************************************************
  // AHB-Lite slave: zero wait states, always OKAY
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp = `EIU_HRESP_OKAY;
  assign hrdata = hrdata_r;
  assign ap_take = hsel & hready & htrans[`EIU_HTRANS_NONSEQ_BIT];
  assign ap_word = haddr[`EIU_WORD_MSB:`EIU_WORD_LSB];
  assign wr_go = dp_valid_r & dp_write_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_word_r <= 4'h0;
    end else if (hready) begin
      dp_valid_r <= ap_take;
      dp_write_r <= hwrite;
      dp_word_r <= ap_word;
    end
  end

  always @* begin
    async_sense_control_nxt = async_sense_control_r;
    sync_sense_control_nxt = sync_sense_control_r;
    line_enable_mask_nxt = line_enable_mask_r;
    if (wr_go) begin
      case (dp_word_r)
        `EIU_OFS_ASYNC_SENSE: async_sense_control_nxt = hwdata[7:0];
        `EIU_OFS_SYNC_SENSE: sync_sense_control_nxt = hwdata[7:0];
        `EIU_OFS_ENABLE_MASK: line_enable_mask_nxt = hwdata[7:0];
        default: async_sense_control_nxt = async_sense_control_r;
      endcase
    end
  end

  // Ones written to the flag word clear, zeros leave flags alone
  assign flag_clr = irq_ack |
    ((wr_go && dp_word_r == `EIU_OFS_REQ_FLAGS) ? hwdata[7:0] : 8'h00);

  // Read data is built from next values so a write just before a read is seen
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (ap_word)
      `EIU_OFS_ASYNC_SENSE: rd_nxt[7:0] = async_sense_control_nxt;
      `EIU_OFS_SYNC_SENSE: rd_nxt[7:0] = sync_sense_control_nxt;
      `EIU_OFS_ENABLE_MASK: rd_nxt[7:0] = line_enable_mask_nxt;
      `EIU_OFS_REQ_FLAGS: rd_nxt[7:0] = line_request_flags_nxt;
      `EIU_OFS_PIN_STATUS: rd_nxt[7:0] = pin_sync_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      async_sense_control_r <= `EIU_RST_ASYNC_SENSE;
    end else begin
      async_sense_control_r <= async_sense_control_nxt;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_sense_control_r <= `EIU_RST_SYNC_SENSE;
    end else begin
      sync_sense_control_r <= sync_sense_control_nxt;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_enable_mask_r <= `EIU_RST_ENABLE_MASK;
    end else begin
      line_enable_mask_r <= line_enable_mask_nxt;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_request_flags_r <= `EIU_RST_REQ_FLAGS;
    end else begin
      line_request_flags_r <= line_request_flags_nxt;
    end
  end

  // Read data is captured in the address phase and stands until the
  // next read, so a master that samples late still sees a stable value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= `EIU_RST_RDATA;
    end else if (ap_take && !hwrite) begin
      hrdata_r <= rd_nxt;
    end
  end

  // Registered request: one cycle of latency buys a glitch-free output
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req_r <= `EIU_RST_IRQ_REQ;
    end else begin
      irq_req_r <= req_nxt;
    end
  end

  // ****************************************************************
  // Pin capture
  // ****************************************************************
  // No second clock exists, so lines 3..0 are oversampled at 8 ns; any
  // pulse of at least EIU_MIN_PULSE_CYC periods is seen by two samples.
  // Pins are read whatever their port direction.
  // Raw pins feed only the first flop; buffer gating acts after the
  // second flop so no logic ever reads an unsettled sample.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_r <= `EIU_RST_PIN_SYNC;
      pin_sync_r <= `EIU_RST_PIN_SYNC;
    end else begin
      pin_meta_r <= ext_irq_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign pin_in = pin_sync_r & ~buf_off;

  // Previous sample, compared with the current one for edge detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_r <= `EIU_RST_PIN_SYNC;
    end else begin
      pin_prev_r[3:0] <= pin_in[3:0];
      // Lines 7..4 only take a new sample while the I/O clock runs
      if (io_clk_run) begin
        pin_prev_r[7:4] <= pin_in[7:4];
      end
    end
  end

  // ****************************************************************
  // Per-line flag and request
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi = gi + 1) begin : g_line
      wire [1:0] sel;
      wire edge_seen;
      wire edge_ok;
      wire flag_src;
      assign sel = sense_all[gi*`EIU_SEL_WIDTH +: `EIU_SEL_WIDTH];
      assign level_mode[gi] = (sel == `EIU_SENSE_LOW);
      if (gi < `EIU_NUM_ASYNC) begin : g_async
        // Buffer is cut off in sleep while the line is disabled
        assign buf_off[gi] = sleep_active & ~line_enable_mask_r[gi];
        assign edge_ok = 1'b1;
      end else begin : g_sync
        assign buf_off[gi] = 1'b0;
        assign edge_ok = io_clk_run;
      end
      assign edge_seen = edge_ok & sense_hit(sel, pin_in[gi], pin_prev_r[gi]);
      // A new edge wins over a clear in the same cycle
      assign line_request_flags_nxt[gi] = level_mode[gi] ? 1'b0 :
        (edge_seen | (line_request_flags_r[gi] & ~flag_clr[gi]));
      // Low level requests straight from the pin, even with the I/O clock halted
      assign flag_src = level_mode[gi] ? ~pin_in[gi] : line_request_flags_r[gi];
      assign req_nxt[gi] = global_irq_en & line_enable_mask_r[gi] & flag_src;
    end
  endgenerate

  // Software must mask a line before changing its sense bits; a change
  // made while enabled may raise one spurious flag.
  assign irq_req = irq_req_r;

endmodule // eiu_ext_irq

// ==== tb/eiu_ext_irq_checker.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Port checker
// ****************************************************************
module eiu_ext_irq_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire hready,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  input wire global_irq_en,
  input wire [7:0] irq_req
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("error response");
  property p_upper; hrdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_gen_off; !$past(global_irq_en) |-> irq_req == 8'h00; endproperty
  a_gen_off: assert property (p_gen_off) else $error("request without enable");
  property p_gen_fell; $fell(global_irq_en) |=> irq_req == 8'h00; endproperty
  a_gen_fell: assert property (p_gen_fell) else $error("request kept");
  property p_req_cause; (|irq_req) |-> $past(global_irq_en); endproperty
  a_req_cause: assert property (p_req_cause) else $error("request uncaused");
  property p_rd_hold;
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_rst_val; $rose(hresetn) |-> irq_req == 8'h00 && hrdata == 32'h0; endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset value");
endmodule // eiu_ext_irq_checker

bind eiu_ext_irq eiu_ext_irq_checker u_eiu_ext_irq_checker (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .hready(hready), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .global_irq_en(global_irq_en), .irq_req(irq_req));

// ==== tb/eiu_core_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// Core side: enters the lowest pending handler
// ****************************************************************
module eiu_core_model (
  input wire hclk,
  input wire hresetn,
  input wire ack_en,
  input wire [7:0] irq_req,
  output reg [7:0] irq_ack
);
  reg [1:0] hold_r;
  // Waits out the request fall-off so one entry is not acknowledged twice
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ack <= 8'h00;
      hold_r <= 2'h0;
    end else if (hold_r != 2'h0) begin
      irq_ack <= 8'h00;
      hold_r <= hold_r - 2'h1;
    end else if (ack_en && irq_req != 8'h00) begin
      irq_ack <= irq_req & (~irq_req + 8'h01);
      hold_r <= 2'h3;
    end
  end
endmodule // eiu_core_model

// ==== tb/test_eiu_ext_irq.sv ====
`timescale 1ns/1ps
`include "eiu_map.vh"
`define EIU_CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_eiu_ext_irq;
  reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, gen = 0, sleep = 0, run = 1, ack_en = 0;
  reg [31:0] haddr = 0, hwdata = 0;
  reg [1:0] htrans = 0;
  reg [7:0] pin = 8'hFF;
  wire hreadyout, hresp;
  wire [31:0] hrdata;
  wire [7:0] irq_req, irq_ack;
  int error_cnt = 0, check_count = 0;
  eiu_ext_irq u_eiu_ext_irq (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_irq_pin(pin),
    .global_irq_en(gen), .sleep_active(sleep), .io_clk_run(run), .irq_ack(irq_ack),
    .irq_req(irq_req));
  eiu_core_model u_eiu_core_model (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en),
    .irq_req(irq_req), .irq_ack(irq_ack));
  initial forever #4 hclk = ~hclk;
  task print_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] ofs, input logic [7:0] wd,
                     input logic [7:0] exp);
    int n;
    n = 0;
    hsel <= 1'b1; haddr <= {26'h0, ofs, 2'h0}; hwrite <= wr; htrans <= 2'h2;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, wd};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin error_cnt++; print_verdict; end
    if (!wr) `EIU_CHK(hrdata, {24'h0, exp})
  endtask
  task automatic wait_req(input int i, input logic e);
    int n;
    for (n = 0; n < 20 && irq_req[i] !== e; n++) @(posedge hclk);
    `EIU_CHK(irq_req[i], e)
    if (irq_req[i] !== e) print_verdict;
  endtask
  task t_reset;
    bus(0, `EIU_OFS_ASYNC_SENSE, 0, `EIU_RST_ASYNC_SENSE);
    bus(0, `EIU_OFS_SYNC_SENSE, 0, `EIU_RST_SYNC_SENSE);
    bus(0, `EIU_OFS_ENABLE_MASK, 0, `EIU_RST_ENABLE_MASK);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, `EIU_RST_REQ_FLAGS);
    bus(0, `EIU_OFS_PIN_STATUS, 0, 8'hFF);
    bus(1, 4'hF, 8'h5A, 0);
    bus(0, 4'hF, 0, 8'h00);
  endtask
  // Lines n=0..3 take codes low, any, fall, rise in both banks
  task t_edges;
    bus(1, `EIU_OFS_ENABLE_MASK, 8'h00, 0);
    bus(1, `EIU_OFS_ASYNC_SENSE, 8'hE4, 0);
    bus(1, `EIU_OFS_SYNC_SENSE, 8'hE4, 0);
    bus(0, `EIU_OFS_ASYNC_SENSE, 0, 8'hE4);
    bus(0, `EIU_OFS_SYNC_SENSE, 0, 8'hE4);
    bus(1, `EIU_OFS_REQ_FLAGS, 8'hFF, 0);
    pin <= 8'h00;
    repeat (6) @(posedge hclk);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'h66);
    pin <= 8'hFF;
    repeat (6) @(posedge hclk);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'hEE);
    bus(1, `EIU_OFS_REQ_FLAGS, 8'h22, 0);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'hCC);
    bus(1, `EIU_OFS_REQ_FLAGS, 8'h00, 0);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'hCC);
  endtask
  task t_req;
    gen <= 1'b1;
    repeat (4) @(posedge hclk);
    `EIU_CHK(irq_req, 8'h00)
    bus(1, `EIU_OFS_ENABLE_MASK, 8'h05, 0);
    wait_req(2, 1'b1);
    gen <= 1'b0;
    wait_req(2, 1'b0);
    gen <= 1'b1;
    wait_req(2, 1'b1);
    pin <= 8'hFE;
    wait_req(0, 1'b1);
    pin <= 8'hFF;
    wait_req(0, 1'b0);
    ack_en <= 1'b1;
    wait_req(2, 1'b0);
    ack_en <= 1'b0;
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'hC8);
  endtask
  task t_pulse;
    bus(1, `EIU_OFS_REQ_FLAGS, 8'hFF, 0);
    pin <= 8'hBB;
    repeat (2) @(posedge hclk);
    pin <= 8'hFB;
    repeat (5) @(posedge hclk);
    pin <= 8'hFF;
    repeat (6) @(posedge hclk);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'h44);
  endtask
  task t_clk_sleep;
    bus(1, `EIU_OFS_REQ_FLAGS, 8'hFF, 0);
    run <= 1'b0;
    pin <= 8'hDF;
    repeat (6) @(posedge hclk);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'h00);
    run <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'h20);
    pin <= 8'hFF;
    repeat (6) @(posedge hclk);
    run <= 1'b0;
    bus(1, `EIU_OFS_ENABLE_MASK, 8'h10, 0);
    pin <= 8'hEF;
    wait_req(4, 1'b1);
    pin <= 8'hFF;
    wait_req(4, 1'b0);
    run <= 1'b1;
    bus(1, `EIU_OFS_REQ_FLAGS, 8'hFF, 0);
    bus(1, `EIU_OFS_ENABLE_MASK, 8'h00, 0);
    sleep <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(0, `EIU_OFS_REQ_FLAGS, 0, 8'h06);
    sleep <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_edges;
    t_req;
    t_pulse;
    t_clk_sleep;
    print_verdict;
  end
endmodule // test_eiu_ext_irq
